// ---- bench/sfc_chk.sv ----
`timescale 1ns/1ps
module sfc_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic        so_oe,
  input wire logic        wp_n_pin,
  input wire logic [3:0]  read_latency_code,
  input wire logic        quad_mode,
  input wire logic        wp_level,
  input wire logic        write_enable_latch,
  input wire logic        checksum_abort_flag,
  input wire logic        crc_start,
  input wire logic [23:0] crc_start_addr,
  input wire logic [23:0] crc_end_addr,
  input wire logic        mem_read_window
);
  // ==========
  // Sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quad_held;
    quad_mode [*6];
  endsequence
  sequence s_plain_held;
    (!quad_mode && wp_n_pin) [*6];
  endsequence
  // ==========
  // Properties
  a_reset_values : assert property (
    $past(rst) |-> !checksum_abort_flag && !write_enable_latch && !quad_mode
      && read_latency_code == 4'h0) else $error("state not clear after reset");
  a_cs_idle : assert property (
    cs_n |-> !so_oe && !mem_read_window) else $error("link output active without frame");
  a_quad_forced : assert property (
    s_quad_held |-> wp_level) else $error("protect not forced in quad mode");
  a_plain_wp : assert property (
    s_plain_held |-> !wp_level) else $error("protect active with pin high");
  a_start_clears : assert property (
    crc_start |-> ##[0:1] !checksum_abort_flag) else $error("abort flag kept on start");
  a_span_ok : assert property (
    crc_start |=> ({1'b0, crc_end_addr} >= {1'b0, crc_start_addr} + 25'h3))
    else $error("checksum started on short range");
  a_start_pulse : assert property (
    crc_start |=> !crc_start) else $error("start pulse too long");
  a_wel_drop : assert property (
    ($changed(read_latency_code) || $changed(quad_mode)) |-> ##[0:1] !write_enable_latch)
    else $error("latch kept after config change");
  a_abort_no_start : assert property (
    $rose(checksum_abort_flag) |-> !crc_start && !$past(crc_start))
    else $error("abort and start together");
endmodule : sfc_chk

bind sfc_top sfc_chk i_sfc_chk (.clk(clk), .rst(rst), .cs_n(cs_n), .so_oe(so_oe),
  .wp_n_pin(wp_n_pin), .read_latency_code(read_latency_code), .quad_mode(quad_mode),
  .wp_level(wp_level), .write_enable_latch(write_enable_latch),
  .checksum_abort_flag(checksum_abort_flag), .crc_start(crc_start),
  .crc_start_addr(crc_start_addr), .crc_end_addr(crc_end_addr),
  .mem_read_window(mem_read_window));

// ---- bench/sfc_host.sv ----
`timescale 1ns/1ps
module sfc_host (
  output logic      sck,
  output logic      cs_n,
  output logic      si_pin,
  input  wire logic so_out
);
  // ==========
  // Single lane host, sck idle low between frames
  initial begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    si_pin = 1'b1;
  end
  task automatic start();
    cs_n = 1'b0;
  endtask : start
  // Fixed 80 ns period, so latency never needs reprogramming
  task automatic shift(input logic b, output logic so);
    si_pin = b;
    #40 sck = 1'b1;
    so = so_out;
    #40 sck = 1'b0;
  endtask : shift
  task automatic stop();
    #40 cs_n = 1'b1;
    si_pin = ~si_pin;  // Released line must not keep last value
    #100;
  endtask : stop
endmodule : sfc_host

// ---- bench/sfc_top_tb.sv ----
`timescale 1ns/1ps
module sfc_top_tb;
  logic        clk, rst, sck, cs_n, si_pin, so_out, so_oe, wp_n_pin, reset_n_pin;
  logic [3:0]  read_latency_code;
  logic        quad_mode, wp_level, write_enable_latch, checksum_abort_flag, crc_start;
  logic [23:0] crc_start_addr, crc_end_addr;
  logic        mem_read_window;
  logic [7:0]  rdv;
  logic        oe_seen;
  int          fails = 0, checked = 0, cycles = 0, starts = 0;

  sfc_top i_sfc_top (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si_pin(si_pin),
    .so_out(so_out), .so_oe(so_oe), .wp_n_pin(wp_n_pin), .reset_n_pin(reset_n_pin),
    .read_latency_code(read_latency_code), .quad_mode(quad_mode), .wp_level(wp_level),
    .write_enable_latch(write_enable_latch), .checksum_abort_flag(checksum_abort_flag),
    .crc_start(crc_start), .crc_start_addr(crc_start_addr), .crc_end_addr(crc_end_addr),
    .mem_read_window(mem_read_window));
  sfc_host i_sfc_host (.sck(sck), .cs_n(cs_n), .si_pin(si_pin), .so_out(so_out));

  // ==========
  // Clock, monitors, closing
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (crc_start === 1'b1) starts <= starts + 1;
    if (cycles == 80000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk

  // ==========
  // Link frames, aligned clear of core clock edges
  task automatic frame(input logic [55:0] v, input int n, input int nr);
    logic so;
    @(negedge clk);
    #1;
    i_sfc_host.start();
    for (int i = 0; i < n; i++) i_sfc_host.shift(v[55-i], so);
    rdv = 8'h00;
    for (int i = 0; i < nr; i++) begin
      i_sfc_host.shift(1'b0, so);
      rdv = {rdv[6:0], so};
    end
    oe_seen = so_oe;
    i_sfc_host.stop();
  endtask : frame
  task automatic op(input logic [7:0] c);
    frame({c, 48'h0}, 8, 0);
  endtask : op
  task automatic reg_write(input logic [23:0] a, input logic [7:0] d);
    frame({sfc_pkg::OP_ADDRESS_REGISTER_WRITE, a, d, 16'h0}, 40, 0);
  endtask : reg_write
  task automatic reg_read(input logic [23:0] a);
    frame({sfc_pkg::OP_ADDRESS_REGISTER_READ, a, 24'h0}, 32, 8);
  endtask : reg_read
  task automatic hw_reset();
    @(negedge clk) reset_n_pin = 1'b0;
    repeat (4) @(negedge clk);
    reset_n_pin = 1'b1;
    repeat (6) @(negedge clk);
  endtask : hw_reset

  // ==========
  // Scenarios
  task automatic t_reset_state();
    frame({sfc_pkg::OP_CONFIG_ONE_READ, 48'h0}, 8, 8);
    chk("config after reset", 8'h00, rdv);
    chk("output enable on read", 1'b1, oe_seen);
    reg_read(sfc_pkg::ADDR_ST2_V);
    chk("status after reset", 8'h00, rdv);
  endtask : t_reset_state
  task automatic t_wel_refuse();
    reg_write(sfc_pkg::ADDR_CFG1_V, 8'hf2);
    chk("no output on write", 1'b0, oe_seen);
    reg_read(sfc_pkg::ADDR_CFG1_V);
    chk("write without latch", 8'h00, rdv);
    op(sfc_pkg::OP_WREN);
    chk("latch set", 1'b1, write_enable_latch);
    op(sfc_pkg::OP_WRDI);
    chk("latch cleared", 1'b0, write_enable_latch);
  endtask : t_wel_refuse
  task automatic t_volatile();
    op(sfc_pkg::OP_WREN);
    reg_write(sfc_pkg::ADDR_CFG1_V, 8'h6d);
    reg_read(sfc_pkg::ADDR_CFG1_V);
    chk("reserved dropped", 8'h60, rdv);
    chk("latency port", 4'h6, read_latency_code);
    chk("latch after write", 1'b0, write_enable_latch);
    hw_reset();
    frame({sfc_pkg::OP_CONFIG_ONE_READ, 48'h0}, 8, 8);
    chk("stored untouched", 8'h00, rdv);
  endtask : t_volatile
  task automatic t_stored();
    op(sfc_pkg::OP_WREN);
    reg_write(sfc_pkg::ADDR_CFG1_NV, 8'ha0);
    frame({sfc_pkg::OP_CONFIG_ONE_READ, 48'h0}, 8, 8);
    chk("stored write live", 8'ha0, rdv);
    op(sfc_pkg::OP_WREN);
    reg_write(sfc_pkg::ADDR_CFG1_V, 8'h30);
    reg_read(sfc_pkg::ADDR_CFG1_NV);
    chk("read gives volatile", 8'h30, rdv);
    hw_reset();
    reg_read(sfc_pkg::ADDR_CFG1_V);
    chk("reload from stored", 8'ha0, rdv);
    reg_read(24'h000005);
    chk("unmapped read", 8'h00, rdv);
  endtask : t_stored
  task automatic t_latency();
    logic [3:0]  codes [3];
    logic [31:0] v;
    logic        so;
    codes = '{4'h0, 4'h6, 4'hf};
    v = {sfc_pkg::OP_FAST_READ, 24'h000100};
    for (int k = 0; k < 3; k++) begin
      op(sfc_pkg::OP_WREN);
      reg_write(sfc_pkg::ADDR_CFG1_V, {codes[k], 4'h0});
      chk("latency code", codes[k], read_latency_code);
      @(negedge clk);
      #1;
      i_sfc_host.start();
      for (int i = 0; i < 32; i++) i_sfc_host.shift(v[31-i], so);
      for (int i = 0; i <= codes[k]; i++) begin
        if (i > 0) i_sfc_host.shift(1'b0, so);
        #1;
        chk("read window", i == codes[k], mem_read_window);
      end
      i_sfc_host.stop();
      chk("window after frame", 1'b0, mem_read_window);
    end
  endtask : t_latency
  task automatic t_quad();
    repeat (8) @(negedge clk);
    chk("protect released", 1'b0, wp_level);
    wp_n_pin = 1'b0;
    repeat (8) @(negedge clk);
    chk("protect from pin", 1'b1, wp_level);
    wp_n_pin = 1'b1;
    op(sfc_pkg::OP_WREN);
    reg_write(sfc_pkg::ADDR_CFG1_V, 8'h02);
    chk("quad on", 1'b1, quad_mode);
    chk("protect forced", 1'b1, wp_level);
    hw_reset();
    chk("reset pin reused", 1'b1, quad_mode);
    op(sfc_pkg::OP_WREN);
    reg_write(sfc_pkg::ADDR_CFG1_V, 8'h00);
    chk("quad off", 1'b0, quad_mode);
  endtask : t_quad
  task automatic t_crc();
    int s0;
    frame({sfc_pkg::OP_CHECKSUM_CALCULATION, 24'h000100, 24'h000102}, 56, 0);
    reg_read(sfc_pkg::ADDR_ST2_V);
    chk("abort in status", 8'h08, rdv);
    reg_read(sfc_pkg::ADDR_ST2_NV);
    chk("abort at other address", 8'h08, rdv);
    s0 = starts;
    frame({sfc_pkg::OP_CHECKSUM_CALCULATION, 24'h000100, 24'h000103}, 56, 0);
    chk("abort cleared", 1'b0, checksum_abort_flag);
    chk("one start", s0 + 1, starts);
    chk("start address", 24'h000100, crc_start_addr);
    chk("end address", 24'h000103, crc_end_addr);
    frame({sfc_pkg::OP_CHECKSUM_CALCULATION, 24'h000200, 24'h000100}, 56, 0);
    op(sfc_pkg::OP_RSTEN);
    op(sfc_pkg::OP_WREN);
    op(sfc_pkg::OP_RST);
    chk("reset needs adjacent enable", 1'b1, checksum_abort_flag);
    op(sfc_pkg::OP_RSTEN);
    op(sfc_pkg::OP_RST);
    chk("soft reset clears", 1'b0, checksum_abort_flag);
    chk("soft reset drops latch", 1'b0, write_enable_latch);
    frame({sfc_pkg::OP_CHECKSUM_CALCULATION, 24'h000200, 24'h000100}, 56, 0);
    chk("end below start", 1'b1, checksum_abort_flag);
    hw_reset();
    chk("pin reset clears", 1'b0, checksum_abort_flag);
  endtask : t_crc

  initial begin
    rst         = 1'b1;
    wp_n_pin    = 1'b1;
    reset_n_pin = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset_state();
    t_wel_refuse();
    t_volatile();
    t_stored();
    t_latency();
    t_quad();
    t_crc();
    end_sim();
  end
endmodule : sfc_top_tb

// ---- verilog/sfc_pkg.sv ----
// What this block does
// - Abort checksum when end below start plus three
// - Successful checksum start clears abort flag
// - Every reset clears the abort flag
// - Volatile copy reloads from stored copy
// - Logic runs only from volatile copy
// - Volatile write leaves stored copy untouched
// - Stored write updates both copies
// - Register reads return the volatile copy
// - Write addresses pick stored or volatile copy
// - Read by own command or either address
// - Latency high nibble, bit1 quad, rest zero
// - Latency code is binary dummy count
// - Latency applies to variable latency reads
// - Each dummy cycle is one clock period
// - Dummy cycles sit between address and data
// - Mode byte cycles counted inside latency
// - Lane counts follow each transfer format; the link here uses the single lane si_pin in and so_out out for all
// - Quad bit selects four data lines; here it only sets quad_mode and the pin functions, and the link stays one lane
// - Quad reuses protect and reset pins
// - Register writes need write enable latch
package sfc_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] OP_WREN                   = 8'h06;
  localparam logic [7:0] OP_WRDI                   = 8'h04;
  localparam logic [7:0] OP_ADDRESS_REGISTER_WRITE = 8'h71;
  localparam logic [7:0] OP_ADDRESS_REGISTER_READ  = 8'h65;
  localparam logic [7:0] OP_CONFIG_ONE_READ        = 8'h35;
  localparam logic [7:0] OP_CHECKSUM_CALCULATION   = 8'h5b;
  localparam logic [7:0] OP_RSTEN                  = 8'h66;
  localparam logic [7:0] OP_RST                    = 8'h99;
  localparam logic [7:0] OP_FAST_READ              = 8'h0b;

  // ==========================================================
  // Register addresses
  localparam logic [23:0] ADDR_CFG1_NV = 24'h000002;
  localparam logic [23:0] ADDR_CFG1_V  = 24'h070002;
  localparam logic [23:0] ADDR_ST2_NV  = 24'h000001;
  localparam logic [23:0] ADDR_ST2_V   = 24'h070001;

  // ==========================================================
  // Fields and reset values
  localparam int          LAT_MSB      = 7;
  localparam int          LAT_LSB      = 4;
  localparam int          QUAD_BIT     = 1;
  localparam int          ABORT_BIT    = 3;
  localparam logic [7:0]  CFG1_WMASK   = 8'hf2;
  localparam logic [7:0]  CFG1_RESET   = 8'h00;
  localparam logic [23:0] CRC_MIN_SPAN = 24'h000003;

  // ==========================================================
  // Frame bit counts, last captured bit index
  localparam logic [5:0] BIT_OPC_LAST  = 6'h07;
  localparam logic [5:0] BIT_ADDR_LAST = 6'h1f;
  localparam logic [5:0] BIT_WDAT_LAST = 6'h27;
  localparam logic [5:0] BIT_CRC_LAST  = 6'h37;
  localparam logic [5:0] BIT_SAT       = 6'h3f;

  // ==========================================================
  // State types
  typedef enum logic [3:0] {
    PH_CMD   = 4'h1,
    PH_ADDR  = 4'h2,
    PH_DUMMY = 4'h4,
    PH_DATA  = 4'h8
  } sfc_phase_e;

  typedef enum logic [1:0] {
    SR_IDLE  = 2'h1,
    SR_ARMED = 2'h2
  } sfc_swrst_e;

endpackage : sfc_pkg

// ---- verilog/sfc_sync.sv ----
`timescale 1ns/1ps
module sfc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // ==========================================================
  // Two stage capture, first stage read only by second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sfc_sync

// ---- verilog/sfc_top.sv ----
`timescale 1ns/1ps
module sfc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si_pin,
  output logic             so_out,
  output logic             so_oe,
  input  wire logic        wp_n_pin,
  input  wire logic        reset_n_pin,
  output logic [3:0]       read_latency_code,
  output logic             quad_mode,
  output logic             wp_level,
  output logic             write_enable_latch,
  output logic             checksum_abort_flag,
  output logic             crc_start,
  output logic [23:0]      crc_start_addr,
  output logic [23:0]      crc_end_addr,
  output logic             mem_read_window
);

  // ==========================================================
  // Address decode helpers
  function automatic logic addr_is_cfg1(input logic [23:0] a);
    addr_is_cfg1 = (a == sfc_pkg::ADDR_CFG1_NV) || (a == sfc_pkg::ADDR_CFG1_V);
  endfunction : addr_is_cfg1

  function automatic logic addr_is_st2(input logic [23:0] a);
    addr_is_st2 = (a == sfc_pkg::ADDR_ST2_NV) || (a == sfc_pkg::ADDR_ST2_V);
  endfunction : addr_is_st2

  // ==========================================================
  // Link side declarations
  logic                frame_rst;
  logic [5:0]          bit_cnt_reg;
  logic [55:0]         shift_reg;
  logic [7:0]          opcode_reg;
  logic [7:0]          out_shift_reg;
  logic                out_active_reg;
  logic [3:0]          dummy_cnt_reg;
  sfc_pkg::sfc_phase_e phase_reg;
  logic [55:0]         shift_next;
  logic [7:0]          opcode_next;
  logic [8:0]          view_link;
  logic                req_tgl_reg;
  logic [7:0]          req_op_reg;
  logic [23:0]         req_addr_reg;
  logic [23:0]         req_end_reg;
  logic [7:0]          req_data_reg;

  // ==========================================================
  // Core side declarations
  logic                req_tgl_sync;
  logic                req_tgl_seen_reg;
  logic                evt;
  logic                rst_pin_n_sync;
  logic                wp_n_sync;
  logic                hw_reset;
  logic                sw_reset_reg;
  sfc_pkg::sfc_swrst_e swrst_reg;
  logic [7:0]          cfg1_nv_reg;
  logic [7:0]          cfg1_v_reg;
  logic [24:0]         crc_min_end;
  logic                reg_write_ok;

  // Frame logic is cleared whenever select is high, since sck may stop
  assign frame_rst   = rst | cs_n;
  assign shift_next  = {shift_reg[54:0], si_pin};
  assign opcode_next = shift_next[7:0];

  // ==========================================================
  // Crossings
  sfc_sync #(.W(1)) u_sync_tgl (
    .clk (clk),
    .rst (rst),
    .d   (req_tgl_reg),
    .q   (req_tgl_sync)
  );

  // Idle level at reset, else a false pin reset and protect follow rst
  sfc_sync #(.W(2), .RST_VAL(2'h3)) u_sync_pins (
    .clk (clk),
    .rst (rst),
    .d   ({reset_n_pin, wp_n_pin}),
    .q   ({rst_pin_n_sync, wp_n_sync})
  );

  // Quasi-static view of registers for the link; stale for two sck edges
  sfc_sync #(.W(9)) u_sync_view (
    .clk (sck),
    .rst (rst),
    .d   ({checksum_abort_flag, cfg1_v_reg}),
    .q   (view_link)
  );

  // ==========================================================
  // Link: bit counter and input shift
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg <= 6'h00;
      shift_reg   <= 56'h0;
    end else begin
      shift_reg <= shift_next;
      if (bit_cnt_reg != sfc_pkg::BIT_SAT) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      opcode_reg <= 8'h00;
    end else if (bit_cnt_reg == sfc_pkg::BIT_OPC_LAST) begin
      opcode_reg <= opcode_next;
    end
  end

  // ==========================================================
  // Link: dummy cycles and data phase of latency reads
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      phase_reg     <= sfc_pkg::PH_CMD;
      dummy_cnt_reg <= 4'h0;
    end else begin
      case (phase_reg)
        sfc_pkg::PH_CMD: begin
          if (bit_cnt_reg == sfc_pkg::BIT_OPC_LAST && opcode_next == sfc_pkg::OP_FAST_READ) begin
            phase_reg <= sfc_pkg::PH_ADDR;
          end
        end
        sfc_pkg::PH_ADDR: begin
          // Count taken from the volatile copy only, mode cycles included
          if (bit_cnt_reg == sfc_pkg::BIT_ADDR_LAST) begin
            dummy_cnt_reg <= view_link[sfc_pkg::LAT_MSB:sfc_pkg::LAT_LSB];
            if (view_link[sfc_pkg::LAT_MSB:sfc_pkg::LAT_LSB] == 4'h0) begin
              phase_reg <= sfc_pkg::PH_DATA;
            end else begin
              phase_reg <= sfc_pkg::PH_DUMMY;
            end
          end
        end
        sfc_pkg::PH_DUMMY: begin
          // One full sck period per dummy cycle in any lane or rate mode
          dummy_cnt_reg <= dummy_cnt_reg - 4'h1;
          if (dummy_cnt_reg == 4'h1) begin
            phase_reg <= sfc_pkg::PH_DATA;
          end
        end
        sfc_pkg::PH_DATA: begin
          phase_reg <= sfc_pkg::PH_DATA;
        end
        default: begin
          phase_reg <= sfc_pkg::PH_CMD;
        end
      endcase
    end
  end

  // ==========================================================
  // Link: register read data, shifted out msb first
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      out_shift_reg  <= 8'h00;
      out_active_reg <= 1'b0;
    end else if (bit_cnt_reg == sfc_pkg::BIT_OPC_LAST &&
                 opcode_next == sfc_pkg::OP_CONFIG_ONE_READ) begin
      out_shift_reg  <= view_link[7:0] & sfc_pkg::CFG1_WMASK;
      out_active_reg <= 1'b1;
    end else if (bit_cnt_reg == sfc_pkg::BIT_ADDR_LAST &&
                 opcode_reg == sfc_pkg::OP_ADDRESS_REGISTER_READ) begin
      out_active_reg <= 1'b1;
      if (addr_is_cfg1(shift_next[23:0])) begin
        out_shift_reg <= view_link[7:0] & sfc_pkg::CFG1_WMASK;
      end else if (addr_is_st2(shift_next[23:0])) begin
        out_shift_reg <= {4'h0, view_link[8], 3'h0};
      end else begin
        out_shift_reg <= 8'h00;
      end
    end else begin
      out_shift_reg <= {out_shift_reg[6:0], 1'b0};
    end
  end

  // Drive on falling edge so the host samples on the rising one
  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_out          <= 1'b0;
      so_oe           <= 1'b0;
      mem_read_window <= 1'b0;
    end else begin
      so_out          <= out_shift_reg[7];
      so_oe           <= out_active_reg;
      mem_read_window <= (phase_reg == sfc_pkg::PH_DATA);
    end
  end

  // ==========================================================
  // Link: request capture, kept across frames for the crossing
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      req_tgl_reg  <= 1'b0;
      req_op_reg   <= 8'h00;
      req_addr_reg <= 24'h0;
      req_end_reg  <= 24'h0;
      req_data_reg <= 8'h00;
    end else if (!cs_n) begin
      if (bit_cnt_reg == sfc_pkg::BIT_OPC_LAST &&
          (opcode_next == sfc_pkg::OP_WREN || opcode_next == sfc_pkg::OP_WRDI ||
           opcode_next == sfc_pkg::OP_RSTEN || opcode_next == sfc_pkg::OP_RST)) begin
        req_op_reg  <= opcode_next;
        req_tgl_reg <= ~req_tgl_reg;
      end else if (bit_cnt_reg == sfc_pkg::BIT_WDAT_LAST &&
                   opcode_reg == sfc_pkg::OP_ADDRESS_REGISTER_WRITE) begin
        req_op_reg   <= opcode_reg;
        req_addr_reg <= shift_next[31:8];
        req_data_reg <= shift_next[7:0];
        req_tgl_reg  <= ~req_tgl_reg;
      end else if (bit_cnt_reg == sfc_pkg::BIT_CRC_LAST &&
                   opcode_reg == sfc_pkg::OP_CHECKSUM_CALCULATION) begin
        req_op_reg   <= opcode_reg;
        req_addr_reg <= shift_next[47:24];
        req_end_reg  <= shift_next[23:0];
        req_tgl_reg  <= ~req_tgl_reg;
      end
    end
  end

  // ==========================================================
  // Core: request event detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_tgl_seen_reg <= 1'b0;
    end else begin
      req_tgl_seen_reg <= req_tgl_sync;
    end
  end

  assign evt          = req_tgl_sync ^ req_tgl_seen_reg;
  assign reg_write_ok = evt && req_op_reg == sfc_pkg::OP_ADDRESS_REGISTER_WRITE &&
                        write_enable_latch;
  // Wide sum so a start near the top of the range cannot wrap
  assign crc_min_end  = {1'b0, req_addr_reg} + {1'b0, sfc_pkg::CRC_MIN_SPAN};

  // Reset pin counts only while it is not serving as a data line
  assign hw_reset = !cfg1_v_reg[sfc_pkg::QUAD_BIT] && !rst_pin_n_sync;

  // ==========================================================
  // Core: software reset sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swrst_reg    <= sfc_pkg::SR_IDLE;
      sw_reset_reg <= 1'b0;
    end else begin
      sw_reset_reg <= 1'b0;
      case (swrst_reg)
        sfc_pkg::SR_IDLE: begin
          if (evt && req_op_reg == sfc_pkg::OP_RSTEN) begin
            swrst_reg <= sfc_pkg::SR_ARMED;
          end
        end
        sfc_pkg::SR_ARMED: begin
          if (evt && req_op_reg == sfc_pkg::OP_RST) begin
            sw_reset_reg <= 1'b1;
            swrst_reg    <= sfc_pkg::SR_IDLE;
          end else if (evt && req_op_reg != sfc_pkg::OP_RSTEN) begin
            swrst_reg <= sfc_pkg::SR_IDLE;
          end
        end
        default: begin
          swrst_reg <= sfc_pkg::SR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Core: stored copy, power cycle model clears it at rst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg1_nv_reg <= sfc_pkg::CFG1_RESET;
    end else if (reg_write_ok && req_addr_reg == sfc_pkg::ADDR_CFG1_NV) begin
      cfg1_nv_reg <= req_data_reg & sfc_pkg::CFG1_WMASK;
    end
  end

  // ==========================================================
  // Core: volatile copy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg1_v_reg <= sfc_pkg::CFG1_RESET;
    end else if (hw_reset) begin
      cfg1_v_reg <= cfg1_nv_reg;
    end else if (reg_write_ok && addr_is_cfg1(req_addr_reg)) begin
      // Volatile address touches only this copy
      cfg1_v_reg <= req_data_reg & sfc_pkg::CFG1_WMASK;
    end
  end

  // ==========================================================
  // Core: write enable latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (hw_reset || sw_reset_reg) begin
      write_enable_latch <= 1'b0;
    end else if (evt && req_op_reg == sfc_pkg::OP_WREN) begin
      write_enable_latch <= 1'b1;
    end else if (evt && (req_op_reg == sfc_pkg::OP_WRDI ||
                         req_op_reg == sfc_pkg::OP_ADDRESS_REGISTER_WRITE)) begin
      write_enable_latch <= 1'b0;
    end
  end

  // ==========================================================
  // Core: checksum start and abort
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      checksum_abort_flag <= 1'b0;
      crc_start           <= 1'b0;
      crc_start_addr      <= 24'h0;
      crc_end_addr        <= 24'h0;
    end else begin
      crc_start <= 1'b0;
      if (hw_reset || sw_reset_reg) begin
        checksum_abort_flag <= 1'b0;
      end else if (evt && req_op_reg == sfc_pkg::OP_CHECKSUM_CALCULATION) begin
        // End below start plus three (CRC_MIN_SPAN) aborts
        if ({1'b0, req_end_reg} < crc_min_end) begin
          checksum_abort_flag <= 1'b1;
        end else begin
          checksum_abort_flag <= 1'b0;
          crc_start           <= 1'b1;
          crc_start_addr      <= req_addr_reg;
          crc_end_addr        <= req_end_reg;
        end
      end
    end
  end

  // ==========================================================
  // Core: pin functions chosen by the quad bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_level <= 1'b0;
    end else begin
      // Protect input is held high while the pin carries data
      wp_level <= cfg1_v_reg[sfc_pkg::QUAD_BIT] ? 1'b1 : ~wp_n_sync;
    end
  end

  // Mode outputs taken from the volatile copy only
  assign read_latency_code = cfg1_v_reg[sfc_pkg::LAT_MSB:sfc_pkg::LAT_LSB];
  assign quad_mode         = cfg1_v_reg[sfc_pkg::QUAD_BIT];

endmodule : sfc_top
